//--- rtl/vbsir_id_rom.sv
`timescale 1ns/1ps
module vbsir_id_rom import vbsir_pkg::*; #(
   parameter logic [39:0] SIGNATURE = 40'h5157_5A4B_54, // Arbitrary value
   parameter logic [23:0] MAKER = 24'h58_595A, // Arbitrary value
   parameter logic [47:0] MODEL = 48'h5437_3235_4E42, // Arbitrary value
   parameter logic [7:0] KB_DIGIT = 8'h31 // ASCII count of decoded kilobytes
) (
   input wire logic [4:0] idx, // Entry index
   output logic [7:0] data // Entry contents
);
   // Fixed lookup; reserved entries answer a constant so reads stay defined
   function automatic logic [7:0] vbsir_id_byte(input logic [4:0] i);
      logic [7:0] b;
      b = VBSIR_UNDEF_BYTE;
      if (i < VBSIR_ID_SIG_END) begin
         b = SIGNATURE[8 * (4 - int'(i)) +: 8];
      end else if (i < VBSIR_ID_MAKER_END) begin
         b = MAKER[8 * (7 - int'(i)) +: 8];
      end else if (i < VBSIR_ID_MODEL_END) begin
         b = MODEL[8 * (13 - int'(i)) +: 8];
      end else if (i == VBSIR_ID_MODEL_SP || i == VBSIR_ID_KB_SP) begin
         b = VBSIR_ASCII_SPACE;
      end else if (i == VBSIR_ID_KB) begin
         b = KB_DIGIT;
      end
      return b;
   endfunction : vbsir_id_byte

   // Pure decode, no state
   always_comb begin
      data = vbsir_id_byte(idx);
   end
endmodule : vbsir_id_rom

//--- rtl/vbsir_pkg.sv
package vbsir_pkg;
   // Board geometry
   localparam int unsigned VBSIR_ADDR_W = 10;
   localparam int unsigned VBSIR_NCH = 8;
   localparam int unsigned VBSIR_ID_IDX_W = 5;

   // Register byte addresses, relative to the board base
   localparam logic [9:0] VBSIR_ID_LAST = 10'h03F;
   localparam logic [9:0] VBSIR_STATUS_ADDR = 10'h081;
   localparam logic [9:0] VBSIR_VEC_FIRST = 10'h0A1;
   localparam logic [9:0] VBSIR_VEC_LAST = 10'h0AF;
   localparam logic [9:0] VBSIR_PEND_ADDR = 10'h0C1;
   localparam logic [9:0] VBSIR_MASK_ADDR = 10'h0C3;

   // Board status field positions
   localparam int unsigned VBSIR_ST_FAILOFF = 0;
   localparam int unsigned VBSIR_ST_PASS = 1;
   localparam int unsigned VBSIR_ST_GPEND = 2;
   localparam int unsigned VBSIR_ST_GIE = 3;
   localparam int unsigned VBSIR_ST_SWRST = 4;

   // Identification area entry indices (entry n sits at byte 2n+1)
   localparam logic [4:0] VBSIR_ID_SIG_END = 5'h05;
   localparam logic [4:0] VBSIR_ID_MAKER_END = 5'h08;
   localparam logic [4:0] VBSIR_ID_MODEL_END = 5'h0E;
   localparam logic [4:0] VBSIR_ID_MODEL_SP = 5'h0E;
   localparam logic [4:0] VBSIR_ID_KB = 5'h0F;
   localparam logic [4:0] VBSIR_ID_KB_SP = 5'h10;
   localparam logic [7:0] VBSIR_ASCII_SPACE = 8'h20;
   localparam logic [7:0] VBSIR_UNDEF_BYTE = 8'h00;

   // Reset values
   localparam logic [7:0] VBSIR_MASK_RST = 8'h00;
   localparam logic [7:0] VBSIR_PEND_RST = 8'h00;

   // One register access from the bus interface logic
   typedef struct packed {
      logic wr;
      logic [9:0] addr;
      logic [7:0] wdata;
   } vbsir_req_t;

   // Per-channel interrupt condition setup (held outside this block)
   typedef struct packed {
      logic [7:0] polarity;
      logic [7:0] cos_sel;
      logic [7:0] pattern_en;
   } vbsir_cond_cfg_t;

   // Whole state of the register block
   typedef struct packed {
      logic gie;
      logic pass_on;
      logic fail_off;
      logic [7:0] mask;
      logic [7:0] pend;
      logic [7:0][7:0] vec;
      logic [7:0] sync1;
      logic [7:0] sync2;
      logic [7:0] prev;
      logic [7:0] rdata;
      logic ack;
      logic irq_n;
      logic [7:0] vector;
      logic iack_ack;
      logic pass_led;
      logic fail_led;
      logic sysfail_oe;
   } vbsir_state_t;
endpackage : vbsir_pkg

//--- rtl/vbsir_regs.sv
`timescale 1ns/1ps
module vbsir_regs import vbsir_pkg::*; #(
   parameter int unsigned NCH = VBSIR_NCH
) (
   input wire logic mclk, // 100 MHz logic clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic ce, // Clock enable, freezes state when low unless rst is high
   input wire logic reg_req, // One-cycle register access strobe
   input wire vbsir_req_t req, // Access write flag, address, data
   output logic [7:0] reg_rdata, // Read data, valid with reg_ack
   output logic reg_ack, // One-cycle access answer
   input wire logic iack_req, // One-cycle interrupt acknowledge strobe
   output logic [7:0] iack_vector, // Vector of the winning channel
   output logic iack_ack, // One-cycle acknowledge answer
   output logic irq_n, // Interrupt request, active low
   input wire logic [NCH-1:0] chan_in, // Raw input channel levels
   input wire vbsir_cond_cfg_t cond_cfg, // Polarity, type and pattern setup
   output logic pass_indicator, // Green indicator, high lights it
   output logic fail_indicator, // Red indicator, high lights it
   output logic sysfail_o, // Failure line drive level
   output logic sysfail_oe // Failure line enable, high drives low
);
   vbsir_state_t q;
   vbsir_state_t d;
   logic [7:0] id_data;
   logic [7:0] cond;
   logic pattern_hit;
   logic [7:0] w1c;
   logic acc_rd;
   logic acc_wr;
   logic sw_reset;

   // Highest-numbered set bit wins; returns channel number
   function automatic logic [2:0] vbsir_top(input logic [7:0] p);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (p[i]) begin
            n = 3'(i);
         end
      end
      return n;
   endfunction : vbsir_top

   // True when the address is an odd byte inside the vector window
   function automatic logic vbsir_is_vec(input logic [9:0] a);
      return (a >= VBSIR_VEC_FIRST) && (a <= VBSIR_VEC_LAST) && a[0];
   endfunction : vbsir_is_vec

   // Identification bytes live in a separate lookup
   vbsir_id_rom u_id (
      .idx(req.addr[VBSIR_ID_IDX_W:1]),
      .data(id_data)
   );

   // Per-channel condition: level match or either-edge change
   genvar g;
   generate
      for (g = 0; g < 8; g++) begin : g_cond
         assign cond[g] = cond_cfg.cos_sel[g] ? (q.sync2[g] ^ q.prev[g])
                        : (q.sync2[g] == cond_cfg.polarity[g]);
      end
   endgenerate

   // Pattern hit needs at least one member, all members at their level
   assign pattern_hit = (|cond_cfg.pattern_en)
      && ((~(q.sync2 ^ cond_cfg.polarity) & cond_cfg.pattern_en) == cond_cfg.pattern_en);

   assign acc_rd = reg_req && !req.wr;
   assign acc_wr = reg_req && req.wr;
   assign sw_reset = acc_wr && (req.addr == VBSIR_STATUS_ADDR)
                     && req.wdata[VBSIR_ST_SWRST];
   assign w1c = (acc_wr && (req.addr == VBSIR_PEND_ADDR)) ? req.wdata : 8'h00;

   // Next-state logic for the whole block
   always_comb begin
      d = q;
      d.ack = 1'b0;
      d.iack_ack = 1'b0;
      d.rdata = 8'h00;
      // Pins cross two flops before anything looks at them
      d.sync1 = chan_in;
      d.sync2 = q.sync1;
      d.prev = q.sync2;
      // Set beats clear so an event in the clearing cycle survives
      d.pend = (q.pend & ~w1c) | (q.mask & cond);
      d.pend[NCH-1] = d.pend[NCH-1] | (q.mask[NCH-1] & pattern_hit);
      if (acc_wr) begin
         if (req.addr == VBSIR_STATUS_ADDR) begin
            d.gie = req.wdata[VBSIR_ST_GIE];
            d.pass_on = req.wdata[VBSIR_ST_PASS];
            d.fail_off = req.wdata[VBSIR_ST_FAILOFF];
         end else if (req.addr == VBSIR_MASK_ADDR) begin
            d.mask = req.wdata;
         end else if (vbsir_is_vec(req.addr)) begin
            d.vec[req.addr[3:1]] = req.wdata;
         end
      end
      if (acc_rd) begin
         if (req.addr <= VBSIR_ID_LAST) begin
            d.rdata = req.addr[0] ? id_data : VBSIR_UNDEF_BYTE;
         end else if (req.addr == VBSIR_STATUS_ADDR) begin
            // Top three bits and the reset trigger always read zero
            d.rdata = 8'h00;
            d.rdata[VBSIR_ST_GIE] = q.gie;
            d.rdata[VBSIR_ST_GPEND] = |q.pend;
            d.rdata[VBSIR_ST_PASS] = q.pass_on;
            d.rdata[VBSIR_ST_FAILOFF] = q.fail_off;
         end else if (req.addr == VBSIR_PEND_ADDR) begin
            d.rdata = q.pend;
         end else if (req.addr == VBSIR_MASK_ADDR) begin
            d.rdata = q.mask;
         end else if (vbsir_is_vec(req.addr)) begin
            d.rdata = q.vec[req.addr[3:1]];
         end
      end
      d.ack = reg_req;
      // Acknowledge hands out the highest pending channel's vector
      if (iack_req) begin
         d.iack_ack = 1'b1;
         d.vector = q.vec[vbsir_top(q.pend)];
      end
      // Any reset clears control and pending but never the vectors
      if (rst || sw_reset) begin
         d.gie = 1'b0;
         d.pass_on = 1'b0;
         d.fail_off = 1'b0;
         d.mask = VBSIR_MASK_RST;
         d.pend = VBSIR_PEND_RST;
         d.vector = 8'h00;
      end
      if (rst) begin
         d.sync1 = 8'h00;
         d.sync2 = 8'h00;
         d.prev = 8'h00;
         d.ack = 1'b0;
         d.iack_ack = 1'b0;
         d.rdata = 8'h00;
      end
      // Request stays low until every pending bit behind it is cleared or the global enable goes off
      d.irq_n = !(d.gie && (|d.pend));
      d.pass_led = d.pass_on;
      d.fail_led = !d.fail_off;
      d.sysfail_oe = !d.fail_off;
   end

   // Reset acts even while the clock enable holds everything else
   always_ff @(posedge mclk) begin
      if (rst || ce) begin
         q <= d;
      end
   end

   assign reg_rdata = q.rdata;
   assign reg_ack = q.ack;
   assign iack_vector = q.vector;
   assign iack_ack = q.iack_ack;
   assign irq_n = q.irq_n;
   assign pass_indicator = q.pass_led;
   assign fail_indicator = q.fail_led;
   assign sysfail_o = 1'b0;
   assign sysfail_oe = q.sysfail_oe;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (rst);

   status_read_zero_a: assert property (
      (ce && acc_rd && req.addr == VBSIR_STATUS_ADDR) |=> (reg_rdata[7:4] == 4'h0)
   ) else $error("status reserved or reset bit read nonzero");

   sw_reset_clear_a: assert property (
      (ce && sw_reset) |=> (q.pend == 8'h00 && q.mask == 8'h00 && irq_n && !q.gie)
   ) else $error("software reset left state set");

   gie_gates_irq_a: assert property (
      (!q.gie) |-> irq_n
   ) else $error("interrupt requested with global enable off");

   gpend_read_a: assert property (
      (ce && acc_rd && req.addr == VBSIR_STATUS_ADDR)
      |=> (reg_rdata[VBSIR_ST_GPEND] == (|$past(q.pend)))
   ) else $error("global pending bit wrong");

   fail_line_a: assert property (
      (sysfail_oe == fail_indicator) && (fail_indicator == !q.fail_off) && !sysfail_o
   ) else $error("fail indicator and failure line disagree");

   masked_no_pend_a: assert property (
      (ce && !q.pend[0] && !q.mask[0]) |=> !q.pend[0]
   ) else $error("masked channel became pending");

   pend_w1c_a: assert property (
      (ce && w1c[1] && !(q.mask[1] && cond[1])) |=> !q.pend[1]
   ) else $error("write one did not clear pending");

   pend_w0_keep_a: assert property (
      (ce && !sw_reset) |=> (($past(q.pend) & ~$past(w1c) & ~q.pend) == 8'h00)
   ) else $error("pending bit lost without write one");

   irq_held_a: assert property (
      (ce && !irq_n && q.gie && w1c == 8'h00 && !sw_reset && !acc_wr) |=> !irq_n
   ) else $error("request dropped before clear");

   prio_vector_a: assert property (
      (ce && !sw_reset && iack_req && q.pend[7])
      |=> (iack_ack && iack_vector == $past(q.vec[7]))
   ) else $error("top channel vector not delivered first");
endmodule : vbsir_regs

//--- test/vbsir_handler.sv
`timescale 1ns/1ps
module vbsir_handler (
   input wire logic mclk, // Logic clock
   input wire logic irq_n, // Request from the board
   input wire logic iack_ack, // Acknowledge answer
   input wire logic [7:0] iack_vector, // Delivered vector
   output logic iack_req // Acknowledge strobe
);
   initial iack_req = 1'b0;
   // One acknowledge cycle; the vector is read in the answer cycle and held until the next acknowledge or reset
   task automatic ack(output logic [7:0] v, output logic hit, output logic asked);
      @(negedge mclk);
      // Record whether a request is standing; the handler acknowledges either way
      asked = !irq_n;
      iack_req = 1'b1;
      @(negedge mclk);
      iack_req = 1'b0;
      hit = iack_ack;
      v = iack_vector;
   endtask : ack
endmodule : vbsir_handler

//--- test/vbsir_regs_tb.sv
`timescale 1ns/1ps
module vbsir_regs_tb import vbsir_pkg::*;;
   logic mclk, rst, ce, reg_req, reg_ack, iack_req, iack_ack, irq_n;
   logic pass_indicator, fail_indicator, sysfail_o, sysfail_oe;
   logic [7:0] reg_rdata, iack_vector, chan_in;
   vbsir_req_t req;
   vbsir_cond_cfg_t cond_cfg;
   int n_fail = 0;
   int n_compared = 0;
   // Expected identification entries; later entries read zero
   logic [0:16][7:0] idt = {8'h51, 8'h57, 8'h5A, 8'h4B, 8'h54, 8'h58, 8'h59, 8'h5A,
      8'h54, 8'h37, 8'h32, 8'h35, 8'h4E, 8'h42, 8'h20, 8'h31, 8'h20};
   vbsir_regs u_vbsir_regs (.mclk(mclk), .rst(rst), .ce(ce), .reg_req(reg_req), .req(req),
      .reg_rdata(reg_rdata), .reg_ack(reg_ack), .iack_req(iack_req),
      .iack_vector(iack_vector), .iack_ack(iack_ack), .irq_n(irq_n), .chan_in(chan_in),
      .cond_cfg(cond_cfg), .pass_indicator(pass_indicator), .fail_indicator(fail_indicator),
      .sysfail_o(sysfail_o), .sysfail_oe(sysfail_oe));
   vbsir_handler u_vbsir_handler (.mclk(mclk), .irq_n(irq_n), .iack_ack(iack_ack),
      .iack_vector(iack_vector), .iack_req(iack_req));
   initial begin
      mclk = 1'b0;
      forever #5 mclk = ~mclk;
   end
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      n_compared++;
      if (s !== e) begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", n, e, s);
      end
   endtask : chk
   task automatic test_done();
      $display("compared %0d, failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : test_done
   task automatic cyc(input int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   // Strobe for one cycle; the answer lands exactly one edge later
   task automatic acc(input logic w, input logic [9:0] a, input logic [7:0] d,
         output logic [7:0] q);
      @(negedge mclk);
      reg_req = 1'b1;
      req = {w, a, d};
      @(negedge mclk);
      reg_req = 1'b0;
      q = reg_rdata;
      chk("ack", {7'h00, reg_ack}, 8'h01);
   endtask : acc
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      logic [7:0] q;
      acc(1'b1, a, d, q);
   endtask : wr
   task automatic rd(input string n, input logic [9:0] a, input logic [7:0] e);
      logic [7:0] q;
      acc(1'b0, a, 8'h00, q);
      chk(n, q, e);
   endtask : rd
   // Request, pass, fail, failure drive packed as one nibble
   task automatic pins(input logic [7:0] e);
      chk("pins", {4'h0, irq_n, pass_indicator, fail_indicator, sysfail_oe}, e);
   endtask : pins
   task automatic iack(input logic [7:0] e);
      logic [7:0] v;
      logic hit;
      logic asked;
      u_vbsir_handler.ack(v, hit, asked);
      chk("irq", {7'h00, asked}, 8'h01);
      chk("iack", {7'h00, hit}, 8'h01);
      chk("vector", v, e);
   endtask : iack
   // Watchdog sized well beyond the few hundred cycles the run needs
   initial begin
      #50000;
      n_fail++;
      test_done();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      reg_req = 1'b0;
      req = '0;
      chan_in = 8'h00;
      cond_cfg = 24'hFF0000;
      cyc(4);
      rst = 1'b0;
      pins(8'h0B);
      rd("status", VBSIR_STATUS_ADDR, 8'h00);
      rd("mask", VBSIR_MASK_ADDR, 8'h00);
      rd("pend", VBSIR_PEND_ADDR, 8'h00);
      for (int i = 0; i < 32; i++)
         rd("id", 10'(2 * i + 1), (i < 17) ? idt[i] : 8'h00);
      rd("even", 10'h002, 8'h00);
      rd("hole", 10'h041, 8'h00);
      wr(VBSIR_STATUS_ADDR, 8'hE3);
      rd("status", VBSIR_STATUS_ADDR, 8'h03);
      pins(8'h0C);
      for (int i = 0; i < 8; i++)
         wr(VBSIR_VEC_FIRST + 10'(2 * i), 8'h40 + 8'(i));
      for (int i = 0; i < 8; i++)
         rd("vec", VBSIR_VEC_FIRST + 10'(2 * i), 8'h40 + 8'(i));
      // Level mode: masked channels must stay quiet
      chan_in = 8'hFF;
      cyc(5);
      rd("pend", VBSIR_PEND_ADDR, 8'h00);
      wr(VBSIR_MASK_ADDR, 8'h81);
      cyc(2);
      rd("pend", VBSIR_PEND_ADDR, 8'h81);
      rd("status", VBSIR_STATUS_ADDR, 8'h07);
      pins(8'h0C);
      wr(VBSIR_STATUS_ADDR, 8'h0B);
      cyc(1);
      pins(8'h04);
      iack(8'h47);
      wr(VBSIR_PEND_ADDR, 8'h80);
      rd("pend", VBSIR_PEND_ADDR, 8'h81);
      chan_in = 8'h00;
      cyc(4);
      // Condition gone, so only the write itself could drop a bit here
      wr(VBSIR_PEND_ADDR, 8'h00);
      rd("pend", VBSIR_PEND_ADDR, 8'h81);
      wr(VBSIR_PEND_ADDR, 8'h80);
      cyc(1);
      rd("pend", VBSIR_PEND_ADDR, 8'h01);
      pins(8'h04);
      iack(8'h40);
      wr(VBSIR_PEND_ADDR, 8'h01);
      cyc(1);
      pins(8'h0C);
      rd("status", VBSIR_STATUS_ADDR, 8'h0B);
      // Change of state: a burst of edges before service merges into one
      cond_cfg = 24'h00FF00;
      wr(VBSIR_MASK_ADDR, 8'hFF);
      chan_in = 8'h08;
      cyc(2);
      chan_in = 8'h00;
      cyc(2);
      chan_in = 8'h08;
      cyc(5);
      rd("pend", VBSIR_PEND_ADDR, 8'h08);
      wr(VBSIR_PEND_ADDR, 8'h08);
      cyc(1);
      rd("pend", VBSIR_PEND_ADDR, 8'h00);
      chan_in = 8'h00;
      cyc(5);
      rd("pend", VBSIR_PEND_ADDR, 8'h08);
      // Pattern on channels 1 and 2 reports on the top channel
      wr(VBSIR_MASK_ADDR, 8'h80);
      cond_cfg = 24'h860006;
      wr(VBSIR_PEND_ADDR, 8'hFF);
      chan_in = 8'h06;
      cyc(5);
      rd("pend", VBSIR_PEND_ADDR, 8'h80);
      wr(VBSIR_MASK_ADDR, 8'h00);
      wr(VBSIR_PEND_ADDR, 8'h80);
      cyc(1);
      rd("pend", VBSIR_PEND_ADDR, 8'h00);
      // Software reset clears state but keeps the vectors
      wr(VBSIR_MASK_ADDR, 8'h80);
      cyc(2);
      // Clock enable low: a strobe is ignored and nothing moves
      ce = 1'b0;
      reg_req = 1'b1;
      req = {1'b1, VBSIR_MASK_ADDR, 8'h00};
      cyc(1);
      reg_req = 1'b0;
      cyc(1);
      chk("ack", {7'h00, reg_ack}, 8'h00);
      ce = 1'b1;
      rd("mask", VBSIR_MASK_ADDR, 8'h80);
      wr(VBSIR_STATUS_ADDR, 8'h1B);
      cyc(1);
      rd("status", VBSIR_STATUS_ADDR, 8'h00);
      rd("mask", VBSIR_MASK_ADDR, 8'h00);
      rd("pend", VBSIR_PEND_ADDR, 8'h00);
      rd("vec", VBSIR_VEC_LAST, 8'h47);
      pins(8'h0B);
      // Hardware reset in mid-run: same clearing, vectors kept
      wr(VBSIR_MASK_ADDR, 8'h80);
      wr(VBSIR_STATUS_ADDR, 8'h0B);
      cyc(2);
      pins(8'h04);
      rst = 1'b1;
      cyc(2);
      rst = 1'b0;
      rd("pend", VBSIR_PEND_ADDR, 8'h00);
      rd("mask", VBSIR_MASK_ADDR, 8'h00);
      rd("vec", VBSIR_VEC_FIRST, 8'h40);
      pins(8'h0B);
      test_done();
   end
endmodule : vbsir_regs_tb
